/* rtl/hthp_host_port.sv */
// hthp_host_port: 8-bit strobed microprocessor port of the
// transceiver: control, mask and coefficient select registers,
// read back of status and datapath values, latched interrupt.
// assumes strobes, address and data are synchronous to clk and
// that the host holds each strobe low for at least two clocks.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - transfers only while chip select low
// - all three strobes low selects hardware mode
// - read strobe low drives selected register
// - write captured at write strobe rising edge
// - interrupt latched low until status read
// - rising edge of four indicators interrupts
// - signal lost interrupts on either edge
// - mask bit blocks that source's interrupt
// - coefficient word split into two bytes
// - any of the three reset inputs restores register defaults
// - decode writes 0,2,3 and reads 0..6
// - write-only control, default zero, mirrors pins in hardware mode
module hthp_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic resetAN,
  input wire logic resetBN,
  // host bus
  input wire logic chipSelectN,
  input wire logic readN,
  input wire logic writeN,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] dataBusIn,
  output logic [7:0] dataBusOut,
  output logic dataBusOe,
  // open-drain interrupt
  output logic intOut,
  output logic intOe,
  // status indicators from the datapath
  input wire logic linkActive,
  input wire logic syncWordLost,
  input wire logic syncWordLostTimer,
  input wire logic timerExpired,
  input wire logic signalLost,
  // datapath values for read back
  input wire logic [7:0] receiverGain,
  input wire logic [7:0] noiseMarginIn,
  input wire logic [7:0] activationIn,
  input wire logic [7:0] stepGainIn,
  input wire logic [15:0] coefWord,
  // control pins used in hardware mode
  input wire logic [7:0] hwControlPins,
  // register contents to the datapath
  output logic [7:0] controlOut,
  output logic [7:0] coefSelect,
  output logic coefReadoutEnable,
  output logic [7:0] intMaskOut,
  output logic hardwareMode
);
  // ==========================================================
  // state
  typedef struct packed {
    hthp_pkg::hthp_bus_e bus; // bus sequencer
    logic [7:0] control; // main control, write only
    logic [7:0] mask; // interrupt mask and coef enable
    logic [7:0] coefSel; // coefficient select
    logic [3:0] wrAddr; // address held during write pulse
    logic [7:0] wrData; // data held during write pulse
    logic [3:0] rdAddr; // address of the read in progress
    logic [7:0] rdData; // byte on the data lines
    logic rdOe; // data lines driven
    logic intPend; // interrupt latch
    logic [15:0] coefHold; // coefficient snapshot
    logic [7:0] effControl; // control seen by the datapath
  } hthp_port_s;
  hthp_port_s st_r;
  hthp_port_s st_nxt;

  // ==========================================================
  // reset: any of the three resets returns all registers
  logic rstAny;
  assign rstAny = ~nrst | ~resetAN | ~resetBN;

  // ==========================================================
  // edge detection of the status indicators
  hthp_evt_if #(.W(hthp_pkg::NUM_SRC)) evtIf ();

  assign evtIf.level = {signalLost, timerExpired, syncWordLostTimer,
                        syncWordLost, linkActive};

  hthp_edge_detect #(
    .W(hthp_pkg::NUM_SRC)
  ) uEdge (
    .clk(clk),
    .clear(rstAny),
    .evt(evtIf)
  );

  // ==========================================================
  // decode helpers
  // true when the address names a writable register
  function automatic logic isWritable(input logic [3:0] a);
    isWritable = (a == hthp_pkg::ADDR_MAIN) ||
                 (a == hthp_pkg::ADDR_MASK) ||
                 (a == hthp_pkg::ADDR_COEF);
  endfunction : isWritable

  // the three strobes low together mean hardware mode, not a cycle
  function automatic logic hwStrap(input logic cs, input logic rd,
                                   input logic wr);
    hwStrap = ~cs & ~rd & ~wr;
  endfunction : hwStrap

  // ==========================================================
  // interrupt sources after masking
  logic [hthp_pkg::NUM_SRC-1:0] srcMask;
  logic [hthp_pkg::NUM_SRC-1:0] srcEvt;
  logic anyEvt;

  assign srcMask = st_r.mask[hthp_pkg::MASK_SRC_LSB +:
                             hthp_pkg::NUM_SRC];
  // four indicators fire on the rise, signal lost on both edges
  assign srcEvt = ((evtIf.rise & hthp_pkg::RISE_SRCS) |
                   ((evtIf.rise | evtIf.fall) &
                    hthp_pkg::FALL_SRCS)) &
                  ~srcMask;
  assign anyEvt = |srcEvt;

  // ==========================================================
  // read sources
  logic coefEn;
  logic [7:0] statusByte;
  logic [7:0] coefLowByte;
  logic [7:0] coefHighByte;
  logic [7:0] muxByte;

  assign coefEn = st_r.mask[hthp_pkg::MASK_COEF_EN];
  // live indicators in the low bits, interrupt latch on top
  always_comb begin
    statusByte = '0;
    statusByte[hthp_pkg::NUM_SRC-1:0] = evtIf.level;
    statusByte[hthp_pkg::STAT_INT] = st_r.intPend;
  end

  // a read of the low byte snapshots the word, so the high byte
  // read afterwards belongs to the same coefficient
  assign coefLowByte = coefEn ? coefWord[7:0] : 8'h00;
  assign coefHighByte = coefEn ? st_r.coefHold[15:8] : 8'h00;

  // a read being taken shows its own register from its first cycle,
  // not the address of the previous read
  logic [3:0] muxAddr;
  assign muxAddr = (st_r.bus == hthp_pkg::ST_IDLE) ? regAddr : st_r.rdAddr;

  hthp_read_mux uMux (
    .addr(muxAddr),
    .mainStatus(statusByte),
    .gainWord(receiverGain),
    .noiseMargin(noiseMarginIn),
    .coefLow(coefLowByte),
    .coefHigh(coefHighByte),
    .actStatus(activationIn),
    .stepGain(stepGainIn),
    .rdByte(muxByte)
  );

  // ==========================================================
  // next state
  logic intClr;

  always_comb begin
    st_nxt = st_r;
    intClr = 1'b0;
    unique case (st_r.bus)
      // waiting for a strobe under chip select
      hthp_pkg::ST_IDLE: begin
        if (hwStrap(chipSelectN, readN, writeN)) begin
          st_nxt.bus = hthp_pkg::ST_HWMODE;
        end else if (!chipSelectN && !writeN) begin
          st_nxt.bus = hthp_pkg::ST_WRITE;
          st_nxt.wrAddr = regAddr;
          st_nxt.wrData = dataBusIn;
        end else if (!chipSelectN && !readN) begin
          st_nxt.bus = hthp_pkg::ST_READ;
          st_nxt.rdAddr = regAddr;
          // snapshot the word when the low byte is read
          if (regAddr == hthp_pkg::ADDR_COEF) begin
            st_nxt.coefHold = coefWord;
          end
        end
      end
      // write pulse low: keep tracking address and data
      hthp_pkg::ST_WRITE: begin
        if (hwStrap(chipSelectN, readN, writeN)) begin
          st_nxt.bus = hthp_pkg::ST_HWMODE;
        end else if (chipSelectN) begin
          // select withdrawn before the rising edge: no transfer
          st_nxt.bus = hthp_pkg::ST_IDLE;
        end else if (!writeN) begin
          st_nxt.wrAddr = regAddr;
          st_nxt.wrData = dataBusIn;
        end else begin
          // rising edge: values held from the last low cycle
          st_nxt.bus = hthp_pkg::ST_IDLE;
          if (isWritable(st_r.wrAddr)) begin
            unique case (st_r.wrAddr)
              hthp_pkg::ADDR_MAIN: st_nxt.control = st_r.wrData;
              hthp_pkg::ADDR_MASK: st_nxt.mask = st_r.wrData;
              hthp_pkg::ADDR_COEF: st_nxt.coefSel = st_r.wrData;
              default: ; // reserved write, dropped
            endcase
          end
        end
      end
      // read pulse low: data lines driven with the live value
      hthp_pkg::ST_READ: begin
        if (hwStrap(chipSelectN, readN, writeN)) begin
          st_nxt.bus = hthp_pkg::ST_HWMODE;
        end else if (chipSelectN || readN) begin
          st_nxt.bus = hthp_pkg::ST_IDLE;
          // the latch drops at the end of a status read
          intClr = (st_r.rdAddr == hthp_pkg::ADDR_MAIN);
        end
      end
      // pin control: wait for any strobe to rise
      hthp_pkg::ST_HWMODE: begin
        if (!hwStrap(chipSelectN, readN, writeN)) begin
          st_nxt.bus = hthp_pkg::ST_IDLE;
        end
      end
    endcase
    // drive only in a read state and only on the same-cycle condition
    st_nxt.rdOe = (st_nxt.bus == hthp_pkg::ST_READ);
    st_nxt.rdData = st_nxt.rdOe ? muxByte : 8'h00;
    // a new event in the clearing cycle keeps the latch set
    st_nxt.intPend = (st_r.intPend & ~intClr) | anyEvt;
    // pins rule in hardware mode, the register in software mode
    st_nxt.effControl = (st_nxt.bus == hthp_pkg::ST_HWMODE) ?
                        hwControlPins : st_nxt.control;
  end

  // ==========================================================
  // register the state
  always_ff @(posedge clk) begin
    if (rstAny) begin
      st_r.bus <= hthp_pkg::ST_IDLE;
      st_r.control <= hthp_pkg::CONTROL_RST;
      st_r.mask <= hthp_pkg::MASK_RST;
      st_r.coefSel <= hthp_pkg::COEFSEL_RST;
      st_r.wrAddr <= '0;
      st_r.wrData <= '0;
      st_r.rdAddr <= '0;
      st_r.rdData <= '0;
      st_r.rdOe <= 1'b0;
      st_r.intPend <= 1'b0;
      st_r.coefHold <= '0;
      st_r.effControl <= hthp_pkg::CONTROL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  // open drain: the pin is only ever pulled low
  assign intOut = 1'b0;
  assign intOe = st_r.intPend;
  assign dataBusOut = st_r.rdData;
  assign dataBusOe = st_r.rdOe;
  assign controlOut = st_r.effControl;
  assign coefSelect = st_r.coefSel;
  assign coefReadoutEnable = coefEn;
  assign intMaskOut = st_r.mask;
  assign hardwareMode = (st_r.bus == hthp_pkg::ST_HWMODE);
endmodule : hthp_host_port
`default_nettype wire

/* rtl/hthp_pkg.sv */
// hthp_pkg: shared constants and types of the transceiver host port.
// assumes all pins are sampled synchronously to the 50 MHz core clock.
package hthp_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_HZ = 50_000_000;
  // ==========================================================
  // register addresses on the 4-bit address pins
  localparam logic [3:0] ADDR_MAIN = 4'h0; // control (wr) / status (rd)
  localparam logic [3:0] ADDR_GAIN = 4'h1; // receiver gain word
  localparam logic [3:0] ADDR_MASK = 4'h2; // mask (wr) / noise margin
  localparam logic [3:0] ADDR_COEF = 4'h3; // coef select / low byte
  localparam logic [3:0] ADDR_COEFHI = 4'h4; // coefficient high byte
  localparam logic [3:0] ADDR_ACT = 4'h5; // activation status
  localparam logic [3:0] ADDR_STEP = 4'h6; // agc and ffe step gain
  // ==========================================================
  // reset values and reserved answer
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] COEFSEL_RST = 8'h00;
  localparam logic [7:0] RESERVED_RD = 8'h00;
  // ==========================================================
  // status sources, index into the event vector
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned SRC_ACTIVE = 0; // link active
  localparam int unsigned SRC_SWL = 1; // sync word lost
  localparam int unsigned SRC_SWLT = 2; // sync word lost timer
  localparam int unsigned SRC_TIMER_EXPIRED = 3; // timer expired
  localparam int unsigned SRC_LOS = 4; // signal lost, both edges
  // sources that fire on a rising edge only
  localparam logic [NUM_SRC-1:0] RISE_SRCS = 5'h0F;
  // sources that fire on a falling edge as well
  localparam logic [NUM_SRC-1:0] FALL_SRCS = 5'h10;
  // ==========================================================
  // interrupt mask register fields
  localparam int unsigned MASK_COEF_EN = 0; // coefficient readout enable
  localparam int unsigned MASK_SRC_LSB = 1; // bits 1..5 mask sources
  // main status register fields
  localparam int unsigned STAT_INT = 7; // interrupt latch
  // ==========================================================
  // bus sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WRITE = 4'h2,
    ST_READ = 4'h4,
    ST_HWMODE = 4'h8
  } hthp_bus_e;
endpackage : hthp_pkg

/* rtl/hthp_evt_if.sv */
// hthp_evt_if: status levels and their edge pulses between the
// host port and its edge detector; one clock domain.
`timescale 1ns/10ps
`default_nettype none
interface hthp_evt_if #(parameter int unsigned W = 5);
  logic [W-1:0] level; // status levels as sampled
  logic [W-1:0] rise; // one-cycle low-to-high pulses
  logic [W-1:0] fall; // one-cycle high-to-low pulses
  modport det(input level, output rise, output fall);
  modport user(output level, input rise, input fall);
endinterface : hthp_evt_if
`default_nettype wire

/* rtl/hthp_edge_detect.sv */
// hthp_edge_detect: turns status levels into edge pulses.
// assumes levels are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module hthp_edge_detect #(
  parameter int unsigned W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic clear,
  // levels in, pulses out
  hthp_evt_if.det evt
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [W-1:0] prev; // level one cycle ago
    logic primed; // prev holds a real sample
  } hthp_edge_s;
  hthp_edge_s st_r;
  hthp_edge_s st_nxt;

  // no edges right after reset: a level already high is not an event
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = evt.level;
    st_nxt.primed = 1'b1;
    evt.rise = st_r.primed ? (evt.level & ~st_r.prev) : '0;
    evt.fall = st_r.primed ? (~evt.level & st_r.prev) : '0;
  end

  // clear is synchronous, like the rest of the block
  always_ff @(posedge clk) begin
    if (clear) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : hthp_edge_detect
`default_nettype wire

/* rtl/hthp_read_mux.sv */
// hthp_read_mux: selects the read register by address.
// assumes every input is already a settled register value.
`timescale 1ns/10ps
`default_nettype none
module hthp_read_mux (
  // selection
  input wire logic [3:0] addr,
  // register contents
  input wire logic [7:0] mainStatus,
  input wire logic [7:0] gainWord,
  input wire logic [7:0] noiseMargin,
  input wire logic [7:0] coefLow,
  input wire logic [7:0] coefHigh,
  input wire logic [7:0] actStatus,
  input wire logic [7:0] stepGain,
  // selected byte
  output logic [7:0] rdByte
);
  // ==========================================================
  // reserved addresses answer a fixed value
  always_comb begin
    unique case (addr)
      hthp_pkg::ADDR_MAIN: rdByte = mainStatus;
      hthp_pkg::ADDR_GAIN: rdByte = gainWord;
      hthp_pkg::ADDR_MASK: rdByte = noiseMargin;
      hthp_pkg::ADDR_COEF: rdByte = coefLow;
      hthp_pkg::ADDR_COEFHI: rdByte = coefHigh;
      hthp_pkg::ADDR_ACT: rdByte = actStatus;
      hthp_pkg::ADDR_STEP: rdByte = stepGain;
      default: rdByte = hthp_pkg::RESERVED_RD;
    endcase
  end
endmodule : hthp_read_mux
`default_nettype wire

/* test/hthp_host_port_props.sv */
// hthp_host_port_props: assertions on the host port pins.
// assumes one clock; any of three low resets idles the port.
`timescale 1ns/10ps
`default_nettype none
module hthp_host_port_props (
  // clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic resetAN,
  input wire logic resetBN,
  // host bus
  input wire logic chipSelectN,
  input wire logic readN,
  input wire logic writeN,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] dataBusOut,
  input wire logic dataBusOe,
  input wire logic intOe,
  // status in, registers out
  input wire logic linkActive,
  input wire logic signalLost,
  input wire logic [7:0] controlOut,
  input wire logic [7:0] coefSelect,
  input wire logic coefReadoutEnable,
  input wire logic [7:0] intMaskOut,
  input wire logic hardwareMode
);
  // ==========================================================
  // clocking and reset
  wire logic anyRst;
  assign anyRst = !nrst || !resetAN || !resetBN;
  default clocking cb @(posedge clk); endclocking
  default disable iff (anyRst);
  // ==========================================================
  // bus assertions
  chk_cs_gate: assert property (chipSelectN |=> !dataBusOe)
    else $error("data lines driven while deselected");
  chk_rd_drive: assert property (!chipSelectN && !readN && writeN
    |=> dataBusOe) else $error("read strobe did not drive bus");
  chk_rd_release: assert property (readN |=> !dataBusOe)
    else $error("bus still driven after read");
  chk_rsvd_zero: assert property (!chipSelectN && !readN && writeN
    && regAddr > 4'h6 |=> dataBusOut == 8'h00)
    else $error("reserved read not zero");
  chk_hw_enter: assert property (!chipSelectN && !readN && !writeN
    |=> hardwareMode) else $error("hardware mode not entered");
  // ==========================================================
  // interrupt assertions
  chk_int_hold: assert property (intOe && readN && $past(readN)
    && $past(readN, 2) |=> intOe) else $error("interrupt latch lost");
  chk_rise_int: assert property ($rose(linkActive)
    && !intMaskOut[1] |-> ##[1:2] intOe) else $error("no rise interrupt");
  chk_los_fall: assert property ($fell(signalLost)
    && !intMaskOut[5] |-> ##[1:2] intOe) else $error("no fall interrupt");
  chk_mask_quiet: assert property (!intOe && (&intMaskOut[5:1])
    |=> !intOe) else $error("masked source raised interrupt");
  chk_coef_enable: assert property (
    coefReadoutEnable == intMaskOut[0]) else $error("readout enable");
  // device resets override the default disable on purpose
  chk_reset_dflt: assert property (disable iff (1'b0)
    !resetAN || !resetBN |=> controlOut == 8'h00 && coefSelect == 8'h00
    && intMaskOut == 8'h00 && !hardwareMode) else $error("reset defaults");
  // ==========================================================
  // coverage of main scenarios
  cov_coef_rd: cover property (!chipSelectN && !readN && regAddr == 4'h3);
  cov_int: cover property ($rose(intOe));
  cov_hw: cover property (hardwareMode);
endmodule : hthp_host_port_props
bind hthp_host_port hthp_host_port_props i_props (.clk, .nrst, .resetAN,
  .resetBN, .chipSelectN, .readN, .writeN, .regAddr, .dataBusOut,
  .dataBusOe, .intOe, .linkActive, .signalLost, .controlOut, .coefSelect,
  .coefReadoutEnable, .intMaskOut, .hardwareMode);
`default_nettype wire

/* test/hthp_host_model.sv */
// hthp_host_model: host processor on the 8-bit strobed bus.
// assumes the port samples all pins on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module hthp_host_model (
  // clock
  input wire logic clk,
  // bus towards the port
  output logic chipSelectN,
  output logic readN,
  output logic writeN,
  output logic [3:0] regAddr,
  output logic [7:0] dataBusIn,
  // answer from the port
  input wire logic [7:0] dataBusOut,
  input wire logic dataBusOe
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    chipSelectN = 1'b1;
    readN = 1'b1;
    writeN = 1'b1;
    regAddr = 4'h0;
    dataBusIn = 8'h00;
  end
  // write: strobe low two clocks, rise with data held
  task wr(input logic [3:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk);
    chipSelectN = sel;
    regAddr = a;
    dataBusIn = d;
    writeN = 1'b0;
    repeat (2) @(negedge clk);
    writeN = 1'b1;
    @(negedge clk);
    chipSelectN = 1'b1;
    // released lines never keep a stale value
    dataBusIn = ~d;
  endtask : wr
  // read: strobe low two clocks, sample while still low
  // status levels are held still around each read, so one read is
  // as good as a frame-aligned one
  task rd(input logic [3:0] a, input logic sel, output logic [7:0] d,
          output logic oe);
    @(negedge clk);
    chipSelectN = sel;
    regAddr = a;
    readN = 1'b0;
    repeat (2) @(negedge clk);
    d = dataBusOut;
    oe = dataBusOe;
    readN = 1'b1;
    @(negedge clk);
    chipSelectN = 1'b1;
  endtask : rd
  // all three strobes low or all released together
  task hw(input logic on);
    @(negedge clk);
    chipSelectN = !on;
    readN = !on;
    writeN = !on;
  endtask : hw
endmodule : hthp_host_model
`default_nettype wire

/* test/hthp_host_port_tb.sv */
// hthp_host_port_tb: self-checking bench of the host port.
// assumes the host model drives the bus; bench drives status.
`timescale 1ns/10ps
`default_nettype none
module hthp_host_port_tb;
  // ==========================================================
  // signals
  logic clk, nrst, resetAN, resetBN, chipSelectN, readN, writeN;
  logic [3:0] regAddr;
  logic [7:0] dataBusIn, dataBusOut, controlOut, coefSelect, intMaskOut;
  logic [7:0] gain, margin, act, step, hwPins, rdData;
  logic [15:0] coefW;
  logic [4:0] lv; // status levels, link active first
  logic dataBusOe, intOut, intOe, coefEn, hwMode, rdOe;
  int n_fail, num_checks;
  hthp_host_model m (.clk(clk), .chipSelectN(chipSelectN), .readN(readN),
    .writeN(writeN), .regAddr(regAddr), .dataBusIn(dataBusIn),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe));
  hthp_host_port i_dut (.clk(clk), .nrst(nrst), .resetAN(resetAN),
    .resetBN(resetBN), .chipSelectN(chipSelectN), .readN(readN),
    .writeN(writeN), .regAddr(regAddr), .dataBusIn(dataBusIn),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe), .intOut(intOut),
    .intOe(intOe), .linkActive(lv[0]), .syncWordLost(lv[1]),
    .syncWordLostTimer(lv[2]), .timerExpired(lv[3]), .signalLost(lv[4]),
    .receiverGain(gain), .noiseMarginIn(margin), .activationIn(act),
    .stepGainIn(step), .coefWord(coefW), .hwControlPins(hwPins),
    .controlOut(controlOut), .coefSelect(coefSelect),
    .coefReadoutEnable(coefEn), .intMaskOut(intMaskOut),
    .hardwareMode(hwMode));
  // ==========================================================
  // helpers
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // three register outputs at once, each compared as a full byte
  task regs(input logic [7:0] c, input logic [7:0] s, input logic [7:0] k);
    chk("control", c, controlOut);
    chk("coefSelect", s, coefSelect);
    chk("mask", k, intMaskOut);
  endtask : regs
  // ==========================================================
  // scenarios
  task t_writes;
    m.wr(hthp_pkg::ADDR_MAIN, 8'hA5, 1'b0);
    m.wr(hthp_pkg::ADDR_COEF, 8'h3C, 1'b0);
    @(negedge clk);
    regs(8'hA5, 8'h3C, 8'h00);
    // reserved write addresses must leave every register alone
    for (int a = 1; a < 16; a++) begin
      if (a != 2 && a != 3) m.wr(4'(a), 8'hFF, 1'b0);
    end
    m.wr(hthp_pkg::ADDR_MAIN, 8'h11, 1'b1);
    @(negedge clk);
    regs(8'hA5, 8'h3C, 8'h00);
  endtask : t_writes
  task t_reads;
    logic [7:0] e [4];
    logic [3:0] a [4];
    e = '{gain, margin, act, step};
    a = '{4'h1, 4'h2, 4'h5, 4'h6};
    for (int i = 0; i < 4; i++) begin
      m.rd(a[i], 1'b0, rdData, rdOe);
      chk("readData", e[i], rdData);
      chk("readOe", 8'h01, {7'h00, rdOe});
    end
    for (int r = 7; r < 16; r++) begin
      m.rd(4'(r), 1'b0, rdData, rdOe);
      chk("reservedRead", hthp_pkg::RESERVED_RD, rdData);
    end
    m.rd(4'h1, 1'b1, rdData, rdOe);
    chk("deselectedOe", 8'h00, {7'h00, rdOe});
    chk("idleOe", 8'h00, {7'h00, dataBusOe});
  endtask : t_reads
  task t_coef;
    m.rd(hthp_pkg::ADDR_COEF, 1'b0, rdData, rdOe);
    chk("coefDisabled", 8'h00, rdData);
    m.wr(hthp_pkg::ADDR_COEF, 8'h05, 1'b0);
    m.wr(hthp_pkg::ADDR_MASK, 8'h01, 1'b0);
    @(negedge clk);
    chk("coefEnable", 8'h01, {7'h00, coefEn});
    m.rd(hthp_pkg::ADDR_COEF, 1'b0, rdData, rdOe);
    chk("coefLow", coefW[7:0], rdData);
    m.rd(hthp_pkg::ADDR_COEFHI, 1'b0, rdData, rdOe);
    chk("coefHigh", coefW[15:8], rdData);
  endtask : t_coef
  // each source: rise, status read clears, then fall
  task t_irq;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      lv[i] = 1'b1;
      repeat (4) @(negedge clk);
      chk("intRise", 8'h01, {7'h00, intOe});
      m.rd(hthp_pkg::ADDR_MAIN, 1'b0, rdData, rdOe);
      chk("status", {3'b100, lv}, rdData);
      @(negedge clk);
      chk("intCleared", 8'h00, {7'h00, intOe});
      lv[i] = 1'b0;
      repeat (4) @(negedge clk);
      chk("intFall", {7'h00, i == 4}, {7'h00, intOe});
      if (i == 4) m.rd(hthp_pkg::ADDR_MAIN, 1'b0, rdData, rdOe);
    end
  endtask : t_irq
  task t_mask;
    m.wr(hthp_pkg::ADDR_MASK, 8'h3F, 1'b0);
    for (int i = 0; i < 10; i++) begin
      repeat (2) @(negedge clk);
      lv[i % 5] = !lv[i % 5];
      repeat (3) @(negedge clk);
      chk("maskedInt", 8'h00, {7'h00, intOe});
    end
  endtask : t_mask
  task t_hw;
    m.hw(1'b1);
    repeat (3) @(negedge clk);
    chk("hwMode", 8'h01, {7'h00, hwMode});
    chk("hwControl", hwPins, controlOut);
    m.hw(1'b0);
    repeat (3) @(negedge clk);
    chk("swControl", 8'hA5, controlOut);
  endtask : t_hw
  // either device reset input restores the defaults
  task t_resets;
    @(negedge clk);
    resetBN = 1'b0;
    @(negedge clk);
    resetBN = 1'b1;
    regs(8'h00, 8'h00, 8'h00);
    m.wr(hthp_pkg::ADDR_MASK, 8'h22, 1'b0);
    @(negedge clk);
    chk("maskBefore", 8'h22, intMaskOut);
    resetAN = 1'b0;
    @(negedge clk);
    resetAN = 1'b1;
    regs(8'h00, 8'h00, 8'h00);
  endtask : t_resets
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    {nrst, resetAN, resetBN, lv} = {3'b011, 5'h00};
    {gain, margin, act, step, hwPins} = 40'h5A33C49681;
    coefW = 16'hBEEF;
    n_fail = 0;
    num_checks = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    regs(8'h00, 8'h00, 8'h00);
    t_writes();
    t_reads();
    t_coef();
    t_irq();
    t_mask();
    t_hw();
    t_resets();
    final_report();
  end
endmodule : hthp_host_port_tb
`default_nettype wire
